// ===== core/pbc_basic_control.sv
// Summary of operation
// - bit 15 soft reset, self-clears, reads one
// - bit 14 loopback, 100M dead time blanking
// - bit 13 speed, reads negotiated when enabled
// - bit 12 negotiation enable, status replaces manual
// - bit 11 power down, bus still answers
// - no spurious MII activity while powered down
// - bit 9 restart, held until negotiation begins
// - restart ignored while negotiation disabled
// - clearing restart never aborts running negotiation
// - bit 8 duplex, reads negotiated when enabled
// - bit 7 collision test ties COL to TX_EN
// - bits 6 to 0 read zero, writes ignored
`timescale 1ns/1ps
`default_nettype none
module pbc_basic_control
    import pbc_pkg::*;
#(
    parameter int unsigned DEAD_CYCLES = PBC_LOOP_DEAD_CYCLES,
    parameter int unsigned RST_CYCLES  = PBC_SOFT_RST_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic        pready,
    output var  logic [31:0] prdata,
    output var  logic        pslverr,
    input  wire logic        an_speed_100,
    input  wire logic        an_full_duplex,
    input  wire logic        an_started,
    input  wire logic        tx_en,
    input  wire logic        phy_col,
    input  wire logic        phy_rx_dv,
    input  wire logic [3:0]  phy_rxd,
    output var  logic        loopback_en,
    output var  logic        speed_100,
    output var  logic        full_duplex,
    output var  logic        autoneg_en,
    output var  logic        power_down,
    output var  logic        isolate,
    output var  logic        an_restart,
    output var  logic        col_test,
    output var  logic        regs_soft_rst,
    output var  logic        rx_blank,
    output var  logic        mii_col,
    output var  logic        mii_rx_dv,
    output var  logic [3:0]  mii_rxd
);

    // ------------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------------
    pbc_bus_t    bus_reg;        // Handshake phase of the bus slave.
    logic        loop_reg;       // Loopback control.
    logic        loop_prev_reg;  // Loopback one cycle ago, for the rising edge.
    logic        speed_reg;      // Manual speed selection.
    logic        an_en_reg;      // Negotiation enable.
    logic        pd_reg;         // Power down control.
    logic        iso_reg;        // Isolate control.
    logic        restart_reg;    // Pending negotiation restart.
    logic        duplex_reg;     // Manual duplex selection.
    logic        coltest_reg;    // Collision test control.
    logic        addr_hit;       // Address decodes to the control register.
    logic        rd_take;        // Access cycle that answers this edge.
    logic        wr_commit;      // Write completes at this edge.
    logic        rst_start;      // Soft reset begins at this edge.
    logic        rst_busy;       // Soft reset sequence is running.
    logic        dead_start;     // Loopback dead time begins.
    logic        speed_eff;      // Speed in force.
    logic        duplex_eff;     // Duplex in force.
    logic [15:0] rd_word;        // Value a read returns.

    // ------------------------------------------------------------------------
    // Bus decode.
    // ------------------------------------------------------------------------
    // The register sits in one aligned word; every other address errors.
    assign addr_hit  = (paddr == PBC_BASIC_CONTROL_OFS);
    // First access edge: the answer is prepared and pready raised.
    assign rd_take   = psel && penable && (bus_reg == PBC_BUS_IDLE);
    // Second access edge: pready is high, so the write takes effect here.
    assign wr_commit = psel && penable && (bus_reg == PBC_BUS_ACK) && pwrite && addr_hit;
    // A write of one to bit 15 launches the soft reset unless one is running.
    assign rst_start = wr_commit && pwdata[PBC_F_SOFT_RST] && !rst_busy;

    // Negotiated results replace the manual choices while negotiation is on.
    assign speed_eff  = an_en_reg ? an_speed_100 : speed_reg;
    assign duplex_eff = an_en_reg ? an_full_duplex : duplex_reg;

    // Read image of the register.
    always_comb begin
        rd_word                   = 16'h0000;
        rd_word[PBC_F_SOFT_RST]   = rst_busy;
        rd_word[PBC_F_LOOPBACK]   = loop_reg;
        rd_word[PBC_F_SPEED]      = speed_eff;
        rd_word[PBC_F_AN_EN]      = an_en_reg;
        rd_word[PBC_F_POWER_DOWN] = pd_reg;
        rd_word[PBC_F_ISOLATE]    = iso_reg;
        rd_word[PBC_F_AN_RESTART] = restart_reg;
        rd_word[PBC_F_DUPLEX]     = duplex_eff;
        rd_word[PBC_F_COL_TEST]   = coltest_reg;
    end

    // ------------------------------------------------------------------------
    // Bus slave.
    // ------------------------------------------------------------------------
    // One wait state: pready rises in the second access cycle and drops after.
    // Power down does not touch this path, so management keeps working.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            bus_reg <= PBC_BUS_IDLE;
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (rd_take) begin
            bus_reg <= PBC_BUS_ACK;
            pready  <= 1'b1;
            prdata  <= (addr_hit && !pwrite) ? {16'h0000, rd_word} : 32'h0000_0000;
            pslverr <= !addr_hit;
        end else begin
            bus_reg <= PBC_BUS_IDLE;
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Control fields.
    // ------------------------------------------------------------------------
    // Soft reset loads the defaults; writes during the sequence are ignored.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            loop_reg    <= PBC_BASIC_CONTROL_RST[PBC_F_LOOPBACK];
            speed_reg   <= PBC_BASIC_CONTROL_RST[PBC_F_SPEED];
            an_en_reg   <= PBC_BASIC_CONTROL_RST[PBC_F_AN_EN];
            pd_reg      <= PBC_BASIC_CONTROL_RST[PBC_F_POWER_DOWN];
            iso_reg     <= PBC_BASIC_CONTROL_RST[PBC_F_ISOLATE];
            duplex_reg  <= PBC_BASIC_CONTROL_RST[PBC_F_DUPLEX];
            coltest_reg <= PBC_BASIC_CONTROL_RST[PBC_F_COL_TEST];
        end else if (rst_start) begin
            loop_reg    <= PBC_BASIC_CONTROL_RST[PBC_F_LOOPBACK];
            speed_reg   <= PBC_BASIC_CONTROL_RST[PBC_F_SPEED];
            an_en_reg   <= PBC_BASIC_CONTROL_RST[PBC_F_AN_EN];
            pd_reg      <= PBC_BASIC_CONTROL_RST[PBC_F_POWER_DOWN];
            iso_reg     <= PBC_BASIC_CONTROL_RST[PBC_F_ISOLATE];
            duplex_reg  <= PBC_BASIC_CONTROL_RST[PBC_F_DUPLEX];
            coltest_reg <= PBC_BASIC_CONTROL_RST[PBC_F_COL_TEST];
        end else if (wr_commit && !rst_busy) begin
            loop_reg    <= pwdata[PBC_F_LOOPBACK];
            speed_reg   <= pwdata[PBC_F_SPEED];
            an_en_reg   <= pwdata[PBC_F_AN_EN];
            pd_reg      <= pwdata[PBC_F_POWER_DOWN];
            iso_reg     <= pwdata[PBC_F_ISOLATE];
            duplex_reg  <= pwdata[PBC_F_DUPLEX];
            coltest_reg <= pwdata[PBC_F_COL_TEST];
        end
    end

    // Restart is only accepted with negotiation enabled in the same word.
    // A written zero never drops it: the engine starting or negotiation turning off clears it,
    // and a new request in that same cycle wins.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            restart_reg <= PBC_BASIC_CONTROL_RST[PBC_F_AN_RESTART];
        end else if (rst_start) begin
            restart_reg <= PBC_BASIC_CONTROL_RST[PBC_F_AN_RESTART];
        end else if (wr_commit && !rst_busy && pwdata[PBC_F_AN_RESTART]
                     && pwdata[PBC_F_AN_EN]) begin
            restart_reg <= 1'b1;
        end else if (an_started || !an_en_reg) begin
            restart_reg <= 1'b0;
        end else if (wr_commit && !rst_busy && !pwdata[PBC_F_AN_EN]) begin
            // Turning negotiation off drops a pending request at once.
            restart_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Sequence timers.
    // ------------------------------------------------------------------------
    // Soft reset keeps bit 15 high and the other registers in reset.
    pbc_timer #(
        .CNT_W (PBC_CNT_W),
        .COUNT (RST_CYCLES)
    ) u_rst_timer (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .start   (rst_start),
        .busy    (rst_busy),
        .done    ()
    );

    // Loopback turned on at 100 Mbps blanks receive data for the dead time.
    assign dead_start = loop_reg && !loop_prev_reg && speed_eff;

    pbc_timer #(
        .CNT_W (PBC_CNT_W),
        .COUNT (DEAD_CYCLES)
    ) u_dead_timer (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .start   (dead_start),
        .busy    (rx_blank),
        .done    ()
    );

    // Loopback history for edge detection.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            loop_prev_reg <= 1'b0;
        end else begin
            loop_prev_reg <= loop_reg;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs to the PHY core.
    // ------------------------------------------------------------------------
    // Registered copies of the controls in force.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            loopback_en   <= 1'b0;
            speed_100     <= 1'b0;
            full_duplex   <= 1'b0;
            autoneg_en    <= 1'b0;
            power_down    <= 1'b0;
            isolate       <= 1'b0;
            an_restart    <= 1'b0;
            col_test      <= 1'b0;
            regs_soft_rst <= 1'b0;
        end else begin
            loopback_en   <= loop_reg;
            speed_100     <= speed_eff;
            full_duplex   <= duplex_eff;
            autoneg_en    <= an_en_reg;
            power_down    <= pd_reg;
            isolate       <= iso_reg;
            an_restart    <= restart_reg;
            col_test      <= coltest_reg;
            regs_soft_rst <= rst_busy;
        end
    end

    // ------------------------------------------------------------------------
    // Internal MII outputs.
    // ------------------------------------------------------------------------
    // Power down and isolate force the outputs quiet; the dead time blanks
    // receive. Collision test mirrors TX_EN onto COL.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mii_col   <= 1'b0;
            mii_rx_dv <= 1'b0;
            mii_rxd   <= 4'h0;
        end else if (pd_reg || iso_reg) begin
            mii_col   <= 1'b0;
            mii_rx_dv <= 1'b0;
            mii_rxd   <= 4'h0;
        end else begin
            mii_col   <= phy_col || (coltest_reg && tx_en);
            mii_rx_dv <= phy_rx_dv && !rx_blank;
            mii_rxd   <= rx_blank ? 4'h0 : phy_rxd;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // First access cycle of a read to the control register.
    sequence s_read_take;
        rd_take && addr_hit && !pwrite;
    endsequence

    // Access cycle followed by the single-cycle answer.
    sequence s_answer;
        pready ##1 !pready;
    endsequence

    a_bus_answers: assert property (rd_take |=> s_answer)
        else $error("bus access not answered in one wait state");

    a_rst_reads_one: assert property (s_read_take and rst_busy |=> prdata[15])
        else $error("reset bit did not read one while running");

    a_rst_defaults: assert property (rst_start |=> rd_word[14:0]
        == {PBC_BASIC_CONTROL_RST[14:14], speed_eff, PBC_BASIC_CONTROL_RST[12:9],
            duplex_eff, PBC_BASIC_CONTROL_RST[7:0]} && rst_busy)
        else $error("soft reset did not load defaults");

    a_loop_blank: assert property ($rose(loop_reg) && speed_eff |=> rx_blank)
        else $error("loopback dead time not started");

    a_speed_status: assert property (s_read_take and an_en_reg
        |=> prdata[13] == $past(an_speed_100) && prdata[8] == $past(an_full_duplex))
        else $error("negotiated speed or duplex not reported");

    a_restart_ignored: assert property (wr_commit && !pwdata[12] |=> !restart_reg)
        else $error("restart accepted with negotiation off");

    a_restart_held: assert property (restart_reg && !an_started && an_en_reg
        && !rst_start && !(wr_commit && !pwdata[PBC_F_AN_EN]) |=> restart_reg)
        else $error("restart dropped before negotiation began");

    a_col_test: assert property (coltest_reg && tx_en && !pd_reg && !iso_reg
        |=> mii_col)
        else $error("collision test did not assert COL");

    a_pd_quiet: assert property (pd_reg |=> !mii_col && !mii_rx_dv && mii_rxd == 4'h0)
        else $error("MII activity while powered down");

    a_rsvd_zero: assert property (pready |-> prdata[6:0] == 7'h00 && prdata[31:16] == 16'h0)
        else $error("reserved bits read nonzero");

    // Writes that land while the soft reset runs leave every field alone.
    a_wr_ignored: assert property (wr_commit && rst_busy
        |=> $stable({loop_reg, speed_reg, an_en_reg, pd_reg, iso_reg, duplex_reg, coltest_reg}))
        else $error("write accepted during soft reset");

    // Receive outputs stay quiet for the whole loopback dead time.
    a_rx_blanked: assert property (rx_blank && !pd_reg && !iso_reg
        |=> !mii_rx_dv && mii_rxd == 4'h0)
        else $error("receive data passed during dead time");

    // A started negotiation clears the pending restart request.
    a_restart_clear: assert property (an_started && !wr_commit |=> !restart_reg)
        else $error("restart bit not cleared after negotiation began");

    // With negotiation off, reads return the manual speed and duplex.
    a_manual_read: assert property (s_read_take and !an_en_reg
        |=> prdata[13] == $past(speed_reg) && prdata[8] == $past(duplex_reg))
        else $error("manual speed or duplex not reported");

    // Without the collision test, COL only follows the raw collision input.
    a_col_normal: assert property (!coltest_reg && !phy_col |=> !mii_col)
        else $error("COL asserted outside collision test");

endmodule
`default_nettype wire

// ===== core/pbc_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants for the basic mode control register block.
// ----------------------------------------------------------------------------
package pbc_pkg;

    // ------------------------------------------------------------------------
    // Clock and timing.
    // ------------------------------------------------------------------------
    // Core clock rate in hertz.
    localparam int unsigned PBC_CLK_FREQ_HZ       = 20000000;
    // Longest loopback dead time in milliseconds.
    localparam int unsigned PBC_LOOP_DEAD_MS      = 720;
    // Dead time in clock cycles, rounded down as a longest time.
    localparam int unsigned PBC_LOOP_DEAD_CYCLES  = PBC_LOOP_DEAD_MS * (PBC_CLK_FREQ_HZ / 1000);
    // Length of the soft reset sequence in clock cycles.
    localparam int unsigned PBC_SOFT_RST_CYCLES   = 16;
    // Width of the sequence counters.
    localparam int unsigned PBC_CNT_W             = 24;

    // ------------------------------------------------------------------------
    // Register map.
    // ------------------------------------------------------------------------
    // Byte address of the basic control register.
    localparam logic [7:0]  PBC_BASIC_CONTROL_OFS = 8'h00;
    // Reset value: 100 Mbps, negotiation enabled, full duplex.
    localparam logic [15:0] PBC_BASIC_CONTROL_RST = 16'h3100;

    // ------------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------------
    localparam int unsigned PBC_F_SOFT_RST   = 15;
    localparam int unsigned PBC_F_LOOPBACK   = 14;
    localparam int unsigned PBC_F_SPEED      = 13;
    localparam int unsigned PBC_F_AN_EN      = 12;
    localparam int unsigned PBC_F_POWER_DOWN = 11;
    localparam int unsigned PBC_F_ISOLATE    = 10;
    localparam int unsigned PBC_F_AN_RESTART = 9;
    localparam int unsigned PBC_F_DUPLEX     = 8;
    localparam int unsigned PBC_F_COL_TEST   = 7;

    // ------------------------------------------------------------------------
    // Bus handshake phase.
    // ------------------------------------------------------------------------
    typedef enum logic [0:0] {
        PBC_BUS_IDLE = 1'b0,
        PBC_BUS_ACK  = 1'b1
    } pbc_bus_t;

endpackage

// ===== core/pbc_timer.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// One-shot sequence timer: busy for exactly COUNT cycles after start.
// ----------------------------------------------------------------------------
module pbc_timer #(
    parameter int unsigned CNT_W = 24,
    parameter int unsigned COUNT = 16
) (
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic start,
    output var  logic busy,
    output var  logic done
);

    // Remaining cycles of the running sequence.
    logic [CNT_W-1:0] cnt_reg;

    // A start while running is ignored so a sequence always runs to its end.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= '0;
            busy    <= 1'b0;
            done    <= 1'b0;
        end else if (start && !busy) begin
            cnt_reg <= CNT_W'(COUNT - 1);
            busy    <= 1'b1;
            done    <= 1'b0;
        end else if (busy && cnt_reg == '0) begin
            busy    <= 1'b0;
            done    <= 1'b1;
        end else begin
            cnt_reg <= busy ? cnt_reg - 1'b1 : cnt_reg;
            done    <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ===== testbench/pbc_neg_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Negotiation engine model: starts a new negotiation after a restart request.
// ----------------------------------------------------------------------------
module pbc_neg_model (
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic an_restart,
    input  wire logic slow,
    output var  logic an_started
);
    logic [7:0] wait_reg;   // Cycles the pending request has waited.

    // Answers after two cycles, or after forty when slow is set.
    // The start pulse lasts one cycle, because the model drops it whenever it is already high.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wait_reg   <= 8'h00;
            an_started <= 1'b0;
        end else if (an_restart && !an_started) begin
            wait_reg   <= wait_reg + 8'h01;
            an_started <= (wait_reg == (slow ? 8'h28 : 8'h02));
        end else begin
            wait_reg   <= 8'h00;
            an_started <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/tb_phy_basic_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_phy_basic_mode_control;
    import pbc_pkg::*;
    localparam int unsigned DEAD = 20;   // Short loopback blanking time.
    logic        sys_clk = 1'b0;
    logic        nrst, psel, penable, pwrite, pready, pslverr, slow;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd_data;
    logic        an_speed_100, an_full_duplex, an_started, tx_en, phy_col;
    logic        phy_rx_dv, loopback_en, speed_100, full_duplex, autoneg_en;
    logic        power_down, isolate, an_restart, col_test, regs_soft_rst;
    logic        rx_blank, mii_col, mii_rx_dv, rd_err;
    logic [3:0]  phy_rxd, mii_rxd;
    int          fails = 0;
    int          total_checks = 0;

    // -------------------------------------------------------------------------
    // Clock, design and negotiation engine model.
    // -------------------------------------------------------------------------
    always #25 sys_clk = ~sys_clk;

    pbc_basic_control #(.DEAD_CYCLES(DEAD), .RST_CYCLES(PBC_SOFT_RST_CYCLES)) i_dut (
        .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .an_speed_100(an_speed_100),
        .an_full_duplex(an_full_duplex), .an_started(an_started), .tx_en(tx_en),
        .phy_col(phy_col), .phy_rx_dv(phy_rx_dv), .phy_rxd(phy_rxd),
        .loopback_en(loopback_en), .speed_100(speed_100), .full_duplex(full_duplex),
        .autoneg_en(autoneg_en), .power_down(power_down), .isolate(isolate),
        .an_restart(an_restart), .col_test(col_test), .regs_soft_rst(regs_soft_rst),
        .rx_blank(rx_blank), .mii_col(mii_col), .mii_rx_dv(mii_rx_dv), .mii_rxd(mii_rxd));

    pbc_neg_model i_neg (.sys_clk(sys_clk), .nrst(nrst), .an_restart(an_restart),
        .slow(slow), .an_started(an_started));

    // -------------------------------------------------------------------------
    // Report, compare and bus tasks.
    // -------------------------------------------------------------------------
    // Prints the verdict and stops the run.
    task automatic complete_run();
        if (fails == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Counts one comparison and reports a mismatch.
    task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; the request stands until pready is sampled high.
    // Written words always keep the isolate bit clear.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= {16'h0000, d & 16'hfbff};
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            complete_run();
        end
        rd_data = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    // Reads an address and compares the word returned.
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 16'h0000);
        compare(what, exp, rd_data);
    endtask

    // Waits, bounded, until the restart request has been raised and taken up.
    task automatic wait_restart();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (an_restart !== 1'b1 && n < 200);
        while (an_restart !== 1'b0 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 200) begin
            fails++;
            complete_run();
        end
    endtask

    // Cuts a hung run short.
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        complete_run();
    end

    // -------------------------------------------------------------------------
    // Main sequence.
    // -------------------------------------------------------------------------
    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata, tx_en, phy_col, slow} = '0;
        {phy_rx_dv, phy_rxd} = '0;
        {an_speed_100, an_full_duplex} = 2'b11;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        rdchk("reset value", 8'h00, 32'h0000_3100);
        an_speed_100   <= 1'b0;
        an_full_duplex <= 1'b0;
        @(posedge sys_clk);
        rdchk("negotiated", 8'h00, 32'h0000_1000);
        compare("speed_100", 32'h0, speed_100);
        compare("full_duplex", 32'h0, full_duplex);
        apb(1'b1, 8'h00, 16'h21ff);
        rdchk("manual", 8'h00, 32'h0000_2180);
        compare("speed_100", 32'h1, speed_100);
        compare("full_duplex", 32'h1, full_duplex);
        tx_en <= 1'b1;
        repeat (2) @(posedge sys_clk);
        compare("mii_col test", 32'h1, mii_col);
        apb(1'b1, 8'h00, 16'h2000);
        @(posedge sys_clk);
        compare("mii_col normal", 32'h0, mii_col);
        apb(1'b1, 8'h00, 16'h0200);
        rdchk("restart ignored", 8'h00, 32'h0000_0000);
        compare("an_restart", 32'h0, an_restart);
        slow <= 1'b1;
        apb(1'b1, 8'h00, 16'h1200);
        rdchk("restart held", 8'h00, 32'h0000_1200);
        apb(1'b1, 8'h00, 16'h1000);
        compare("an_restart kept", 32'h1, an_restart);
        wait_restart();
        rdchk("restart done", 8'h00, 32'h0000_1000);
        slow <= 1'b0;
        apb(1'b1, 8'h00, 16'h1200);
        wait_restart();
        rdchk("prompt restart", 8'h00, 32'h0000_1000);
        phy_rx_dv <= 1'b1;
        phy_rxd   <= 4'ha;
        repeat (2) @(posedge sys_clk);
        compare("mii_rxd", 32'ha, mii_rxd);
        apb(1'b1, 8'h00, 16'h0880);
        rdchk("power down", 8'h00, 32'h0000_0880);
        compare("power_down", 32'h1, power_down);
        compare("col_test", 32'h1, col_test);
        compare("autoneg_en", 32'h0, autoneg_en);
        compare("mii quiet", 32'h0, {mii_col, mii_rx_dv, mii_rxd});
        apb(1'b1, 8'h00, 16'h6000);
        repeat (3) @(posedge sys_clk);
        compare("blanked", 32'h2, {rx_blank, mii_rx_dv});
        compare("loopback_en", 32'h1, loopback_en);
        repeat (DEAD + 5) @(posedge sys_clk);
        compare("unblanked", 32'h1, {rx_blank, mii_rx_dv});
        an_speed_100   <= 1'b1;
        an_full_duplex <= 1'b1;
        apb(1'b1, 8'h00, 16'h8000);
        rdchk("soft reset", 8'h00, 32'h0000_b100);
        compare("regs_soft_rst", 32'h1, regs_soft_rst);
        apb(1'b1, 8'h00, 16'h0000);
        repeat (PBC_SOFT_RST_CYCLES + 4) @(posedge sys_clk);
        rdchk("after soft reset", 8'h00, 32'h0000_3100);
        compare("loopback_en", 32'h0, loopback_en);
        compare("autoneg_en", 32'h1, autoneg_en);
        compare("regs_soft_rst", 32'h0, regs_soft_rst);
        compare("isolate", 32'h0, isolate);
        apb(1'b1, 8'h08, 16'h0000);
        compare("unmapped write", 32'h1, rd_err);
        rdchk("unmapped read", 8'h04, 32'h0000_0000);
        compare("unmapped err", 32'h1, rd_err);
        rdchk("kept value", 8'h00, 32'h0000_3100);
        complete_run();
    end
endmodule
`default_nettype wire
